// ### rtl/clk_mode_defines.svh
`ifndef CLK_MODE_DEFINES_SVH
`define CLK_MODE_DEFINES_SVH

// ==========================================================
// register map
`define SYSCLK_ADDR 8'h00
`define FOSC_ADDR 8'h01
`define SYSCLK_RESET 8'h00
`define FOSC_RESET 8'h01
`define SYSCLK_WR_MASK 8'he3
`define FOSC_WR_MASK 8'h0d

// ==========================================================
// field positions
`define SYSCLK_SEL_HI 7
`define SYSCLK_SEL_LO 5
`define SYSCLK_FAST_KEEP 1
`define SYSCLK_SLOW_KEEP 0
`define FOSC_FREQ_HI 3
`define FOSC_FREQ_LO 2
`define FOSC_STABLE 1
`define FOSC_ON 0

// ==========================================================
// encodings
`define SEL_FAST_DIV1 3'h0
`define SEL_SUB 3'h7
`define FREQ_4M 2'h0
`define FREQ_8M 2'h1
`define FREQ_12M 2'h2

// ==========================================================
// rates in kHz, phase accumulator arithmetic
`define REF_KHZ 19'h3_d090
`define FAST_4M_KHZ 19'h0fa0
`define FAST_8M_KHZ 19'h1f40
`define FAST_12M_KHZ 19'h2ee0
`define SLOW_KHZ 19'h0020

// ==========================================================
// timing
`define REF_PERIOD_PS 4000
`define FAST_STABLE_NS 1024
`define FAST_STABLE_CYCLES \
    10'(((`FAST_STABLE_NS * 1000) + `REF_PERIOD_PS - 1) / `REF_PERIOD_PS)
`define SW_CUR_PERIODS 3'h4

`endif

// ### rtl/clk_mode_pkg.sv
package clk_mode_pkg;

    typedef enum logic [2:0] {
        PWR_RUN,
        PWR_SLEEP,
        PWR_DOZE_SUB_ONLY,
        PWR_DOZE_BOTH_CLOCKS,
        PWR_DOZE_FAST_ONLY
    } power_state_t;

    typedef enum logic [1:0] {
        SW_IDLE,
        SW_COUNT,
        SW_WAIT_TAR
    } switch_state_t;

    typedef struct packed {
        logic [18:0] acc;
    } osc_state_t;

    typedef struct packed {
        logic [5:0] div_cnt;
        logic [2:0] cur_sel;
        logic [2:0] tgt_sel;
        logic [2:0] cnt;
        switch_state_t st;
    } switch_state_reg_t;

    typedef struct packed {
        logic [2:0] sys_clk_select;
        logic fast_osc_keep_on_stop;
        logic slow_osc_keep_on_stop;
        logic [1:0] fast_osc_freq_select;
        logic fast_osc_on;
        logic fast_osc_stable_flag;
        logic [1:0] freq_active;
        logic [9:0] stable_cnt;
        logic osc_was_run;
        power_state_t pwr;
        logic [7:0] rd_data;
    } ctrl_state_t;

endpackage

// ### rtl/rc_osc_tick.sv
`timescale 1ns/1ps
`include "clk_mode_defines.svh"

// ==========================================================
// oscillator model: one-cycle enable at freq_khz on average
module rc_osc_tick
    import clk_mode_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic run,
    input wire logic [18:0] freq_khz,
    output logic tick
);
    osc_state_t s_r;
    osc_state_t s_nxt;
    logic [18:0] sum;

    always_comb
    begin
        sum = s_r.acc + freq_khz;
        s_nxt = s_r;
        tick = 1'b0;
        if (!run)
        begin
            // stopped oscillator restarts from a clean phase
            s_nxt.acc = '0;
        end
        else if (sum >= `REF_KHZ)
        begin
            s_nxt.acc = sum - `REF_KHZ;
            tick = 1'b1;
        end
        else
        begin
            s_nxt.acc = sum;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end
endmodule // rc_osc_tick

// ### rtl/sys_clk_switch.sv
`timescale 1ns/1ps
`include "clk_mode_defines.svh"

// ==========================================================
// fast divider and glitch-free system clock source switch
module sys_clk_switch
    import clk_mode_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic fast_tick,
    input wire logic slow_tick,
    input wire logic [2:0] sel,
    output logic sys_tick,
    output logic [6:0] fast_div_tick,
    output logic busy
);
    switch_state_reg_t s_r;
    switch_state_reg_t s_nxt;
    logic [7:0] src_tick;
    logic cur_tick;
    logic tar_tick;

    // divide by 2^i: tick when the low i counter bits are all ones
    genvar i;
    generate
        for (i = 0; i < 7; i++)
        begin : g_div
            localparam logic [5:0] LOW_ONES = 6'((1 << i) - 1);
            assign fast_div_tick[i] = fast_tick & (&(s_r.div_cnt | ~LOW_ONES));
        end
    endgenerate

    assign src_tick = {slow_tick, fast_div_tick};
    assign cur_tick = src_tick[s_r.cur_sel];
    assign tar_tick = src_tick[s_r.tgt_sel];
    assign busy = (s_r.st != SW_IDLE);
    // output held low while waiting for the incoming edge: no runt pulse
    assign sys_tick = (s_r.st == SW_WAIT_TAR) ? tar_tick : cur_tick;

    always_comb
    begin
        s_nxt = s_r;
        if (fast_tick)
            s_nxt.div_cnt = s_r.div_cnt + 6'h01;
        if (s_r.st != SW_IDLE && sel == s_r.cur_sel)
        begin
            s_nxt.st = SW_IDLE;
        end
        else if (sel != s_r.cur_sel && sel != s_r.tgt_sel || s_r.st == SW_IDLE
                 && sel != s_r.cur_sel)
        begin
            // any new target restarts the wait
            s_nxt.tgt_sel = sel;
            s_nxt.cnt = '0;
            s_nxt.st = SW_COUNT;
        end
        else
        begin
            unique case (s_r.st)
                SW_IDLE:
                begin
                    s_nxt.tgt_sel = s_r.cur_sel;
                end
                SW_COUNT:
                begin
                    // four outgoing periods keep running first
                    if (cur_tick)
                    begin
                        s_nxt.cnt = s_r.cnt + 3'h1;
                        if (s_r.cnt == `SW_CUR_PERIODS - 3'h1)
                            s_nxt.st = SW_WAIT_TAR;
                    end
                end
                SW_WAIT_TAR:
                begin
                    if (tar_tick)
                    begin
                        s_nxt.cur_sel = s_r.tgt_sel;
                        s_nxt.st = SW_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            s_r <= '{div_cnt: 6'h00, cur_sel: `SEL_FAST_DIV1, tgt_sel: `SEL_FAST_DIV1,
                     cnt: 3'h0, st: SW_IDLE};
        else
            s_r <= s_nxt;
    end
endmodule // sys_clk_switch

// ### rtl/system_clock_mode_control.sv
// Behaviour
// - select 000 fast undivided, 001-110 fast divided 2..64, 111 sub clock
// - fast oscillator runs at 4, 8 or 12 MHz by frequency select
// - frequency select 00=4, 01=8, 10=12, 11=4 MHz
// - sub clock comes from the 32 kHz slow oscillator
// - fast mode: CPU on divided fast clock, all clocks on
// - slow mode: CPU on sub clock, sub and slow clocks on
// - sub-clocked system: fast oscillator runs or stops by its enable bit
// - halt with both keep bits 0: sleep, all clocks stop except the slow and watchdog clocks while watchdog is enabled
// - slow oscillator always on, except sleep where watchdog enable decides
// - halt keep 01: fast off, sub on, system only when select 111
// - halt keep 11: fast, sub and system clocks all on
// - halt keep 10: fast on, sub off, system only when select below 111
// - switch completes within four current periods plus partial source periods
// - control register bits 4 to 2 read zero
// - slow oscillator also feeds watchdog and time base clocks
// - stable flag clears on enable, sets when stable; new frequency then
`timescale 1ns/1ps
`include "clk_mode_defines.svh"

module system_clock_mode_control
    import clk_mode_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rd_data,
    input wire logic halt_req,
    input wire logic wake_req,
    input wire logic watchdog_en,
    output logic cpu_clk_en,
    output logic system_clk_en,
    output logic fast_clk_en,
    output logic [6:0] fast_div_en,
    output logic sub_clk_en,
    output logic slow_osc_clk_en,
    output logic watchdog_clk_en,
    output logic time_base_clk_en,
    output logic fast_osc_run,
    output logic slow_osc_run,
    output logic fast_osc_stable_flag,
    output logic switch_busy,
    output power_state_t power_mode
);
    ctrl_state_t s_r;
    ctrl_state_t s_nxt;

    logic sel_is_sub;
    logic fast_raw_tick;
    logic fast_tick;
    logic slow_tick;
    logic sys_tick;
    logic [18:0] fast_khz;
    logic sub_gate;
    logic fast_gate;
    logic sys_gate;
    logic [7:0] sysclk_view;
    logic [7:0] fosc_view;

    assign sel_is_sub = (s_r.sys_clk_select == `SEL_SUB);

    // ==========================================================
    // register views
    always_comb
    begin
        sysclk_view = '0; // unimplemented bits stay zero
        sysclk_view[`SYSCLK_SEL_HI:`SYSCLK_SEL_LO] = s_r.sys_clk_select;
        sysclk_view[`SYSCLK_FAST_KEEP] = s_r.fast_osc_keep_on_stop;
        sysclk_view[`SYSCLK_SLOW_KEEP] = s_r.slow_osc_keep_on_stop;
        fosc_view = '0;
        fosc_view[`FOSC_FREQ_HI:`FOSC_FREQ_LO] = s_r.fast_osc_freq_select;
        fosc_view[`FOSC_STABLE] = s_r.fast_osc_stable_flag;
        fosc_view[`FOSC_ON] = s_r.fast_osc_on;
    end

    // ==========================================================
    // fast oscillator frequency, from the frequency in effect
    always_comb
    begin
        unique case (s_r.freq_active)
            `FREQ_8M: fast_khz = `FAST_8M_KHZ;
            `FREQ_12M: fast_khz = `FAST_12M_KHZ;
            default: fast_khz = `FAST_4M_KHZ; // 00 and 11 both 4 MHz
        endcase
    end

    // ==========================================================
    // oscillator power per mode
    always_comb
    begin
        fast_osc_run = 1'b0;
        sub_gate = 1'b0;
        fast_gate = 1'b0;
        sys_gate = 1'b0;
        slow_osc_run = 1'b1;
        unique case (s_r.pwr)
            PWR_RUN:
            begin
                // fast source needed unless sub-clocked with enable off
                fast_osc_run = !sel_is_sub || s_r.fast_osc_on;
                fast_gate = 1'b1;
                sub_gate = 1'b1;
                sys_gate = 1'b1;
            end
            PWR_SLEEP:
            begin
                // watchdog alone keeps the slow oscillator alive
                slow_osc_run = watchdog_en;
            end
            PWR_DOZE_SUB_ONLY:
            begin
                sub_gate = 1'b1;
                sys_gate = sel_is_sub;
            end
            PWR_DOZE_BOTH_CLOCKS:
            begin
                fast_osc_run = 1'b1;
                fast_gate = 1'b1;
                sub_gate = 1'b1;
                sys_gate = 1'b1;
            end
            PWR_DOZE_FAST_ONLY:
            begin
                fast_osc_run = 1'b1;
                fast_gate = 1'b1;
                sys_gate = !sel_is_sub;
            end
        endcase
    end

    // ==========================================================
    // oscillators and system clock path
    rc_osc_tick u_fast_osc (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .run(fast_osc_run),
        .freq_khz(fast_khz),
        .tick(fast_raw_tick)
    );

    rc_osc_tick u_slow_osc (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .run(slow_osc_run),
        .freq_khz(`SLOW_KHZ),
        .tick(slow_tick)
    );

    // unstable oscillator output never leaves the block
    assign fast_tick = fast_raw_tick & s_r.fast_osc_stable_flag;

    sys_clk_switch u_switch (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .fast_tick(fast_tick),
        .slow_tick(slow_tick),
        .sel(s_r.sys_clk_select),
        .sys_tick(sys_tick),
        .fast_div_tick(fast_div_en),
        .busy(switch_busy)
    );

    // ==========================================================
    // clock enables handed to the consumers
    assign fast_clk_en = fast_tick & fast_gate;
    assign sub_clk_en = slow_tick & sub_gate;
    assign slow_osc_clk_en = slow_tick;
    assign system_clk_en = sys_tick & sys_gate;
    assign cpu_clk_en = system_clk_en & (s_r.pwr == PWR_RUN);
    assign watchdog_clk_en = slow_tick;
    assign time_base_clk_en = sub_clk_en;
    assign fast_osc_stable_flag = s_r.fast_osc_stable_flag;
    assign power_mode = s_r.pwr;
    assign rd_data = s_r.rd_data;

    // ==========================================================
    // next state
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.rd_data = '0;
        s_nxt.osc_was_run = fast_osc_run;

        // software writes
        if (wr_en && addr == `SYSCLK_ADDR)
        begin
            s_nxt.sys_clk_select = wdata[`SYSCLK_SEL_HI:`SYSCLK_SEL_LO];
            s_nxt.fast_osc_keep_on_stop = wdata[`SYSCLK_FAST_KEEP];
            s_nxt.slow_osc_keep_on_stop = wdata[`SYSCLK_SLOW_KEEP];
        end
        if (wr_en && addr == `FOSC_ADDR)
        begin
            s_nxt.fast_osc_freq_select = wdata[`FOSC_FREQ_HI:`FOSC_FREQ_LO];
            s_nxt.fast_osc_on = wdata[`FOSC_ON];
        end

        // reads answer in the following cycle only
        if (rd_en)
        begin
            if (addr == `SYSCLK_ADDR)
                s_nxt.rd_data = sysclk_view & `SYSCLK_WR_MASK;
            else if (addr == `FOSC_ADDR)
                s_nxt.rd_data = fosc_view;
        end

        // stabilisation: restart on power-up or on a new frequency request
        if (!fast_osc_run)
        begin
            s_nxt.fast_osc_stable_flag = 1'b0;
            s_nxt.stable_cnt = '0;
        end
        else if (!s_r.osc_was_run
                 || s_r.fast_osc_freq_select != s_r.freq_active)
        begin
            // flag drops and the new frequency takes effect in the same cycle
            s_nxt.fast_osc_stable_flag = 1'b0;
            s_nxt.stable_cnt = '0;
            s_nxt.freq_active = s_r.fast_osc_freq_select;
        end
        else if (!s_r.fast_osc_stable_flag)
        begin
            s_nxt.stable_cnt = s_r.stable_cnt + 10'h001;
            if (s_r.stable_cnt == `FAST_STABLE_CYCLES - 10'h001)
                s_nxt.fast_osc_stable_flag = 1'b1;
        end

        // halt and wake; halt only from a running CPU
        unique case (s_r.pwr)
            PWR_RUN:
            begin
                if (halt_req)
                begin
                    unique case ({s_r.fast_osc_keep_on_stop, s_r.slow_osc_keep_on_stop})
                        2'b00: s_nxt.pwr = PWR_SLEEP;
                        2'b01: s_nxt.pwr = PWR_DOZE_SUB_ONLY;
                        2'b11: s_nxt.pwr = PWR_DOZE_BOTH_CLOCKS;
                        2'b10: s_nxt.pwr = PWR_DOZE_FAST_ONLY;
                    endcase
                end
            end
            PWR_SLEEP, PWR_DOZE_SUB_ONLY, PWR_DOZE_BOTH_CLOCKS, PWR_DOZE_FAST_ONLY:
            begin
                if (wake_req)
                    s_nxt.pwr = PWR_RUN;
            end
        endcase
    end

    // ==========================================================
    // state register
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s_r <= '{sys_clk_select: 3'(`SYSCLK_RESET >> `SYSCLK_SEL_LO),
                     fast_osc_keep_on_stop: 1'b0,
                     slow_osc_keep_on_stop: 1'b0,
                     fast_osc_freq_select: `FREQ_4M,
                     fast_osc_on: 1'b1,
                     fast_osc_stable_flag: 1'b0,
                     freq_active: `FREQ_4M,
                     stable_cnt: 10'h000,
                     osc_was_run: 1'b0,
                     pwr: PWR_RUN,
                     rd_data: 8'h00};
        end
        else
        begin
            s_r <= s_nxt;
        end
    end
endmodule // system_clock_mode_control

// ### test/clock_mode_sva.sv
`timescale 1ns/1ps
// ==========================================
// port checker for the clock mode block
module clock_mode_sva
    import clk_mode_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [7:0] addr,
    input wire logic rd_en,
    input wire logic [7:0] rd_data,
    input wire logic halt_req,
    input wire logic watchdog_en,
    input wire logic cpu_clk_en,
    input wire logic system_clk_en,
    input wire logic fast_clk_en,
    input wire logic [6:0] fast_div_en,
    input wire logic sub_clk_en,
    input wire logic slow_osc_clk_en,
    input wire logic watchdog_clk_en,
    input wire logic time_base_clk_en,
    input wire logic fast_osc_run,
    input wire logic slow_osc_run,
    input wire logic fast_osc_stable_flag,
    input wire logic switch_busy,
    input wire power_state_t power_mode
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    // worst switches seen by the bench: /64 of 12 MHz to undivided, undivided 12 MHz to the sub clock
    logic [15:0] busy_cnt_r;
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            busy_cnt_r <= 16'h0000;
        else
            busy_cnt_r <= switch_busy ? busy_cnt_r + 16'h0001 : 16'h0000;
    end

    property p_rd_reserved;
        rd_en && addr == 8'h00 |=> rd_data[4:2] == 3'h0;
    endproperty
    a_rd_reserved: assert property (p_rd_reserved) else $error("reserved bits read high");
    property p_cpu_gate;
        cpu_clk_en |-> system_clk_en && power_mode == PWR_RUN;
    endproperty
    a_cpu_gate: assert property (p_cpu_gate) else $error("cpu clock outside run");
    property p_sleep_gate;
        power_mode == PWR_SLEEP |-> !system_clk_en && !fast_clk_en && !sub_clk_en;
    endproperty
    a_sleep_gate: assert property (p_sleep_gate) else $error("clock alive in sleep");
    property p_slow_on;
        power_mode != PWR_SLEEP |-> slow_osc_run;
    endproperty
    a_slow_on: assert property (p_slow_on) else $error("slow osc stopped");
    property p_sleep_wdt;
        power_mode == PWR_SLEEP |-> slow_osc_run == watchdog_en;
    endproperty
    a_sleep_wdt: assert property (p_sleep_wdt) else $error("slow osc vs watchdog");
    property p_doze_sub;
        power_mode == PWR_DOZE_SUB_ONLY |-> !fast_clk_en && !fast_osc_run;
    endproperty
    a_doze_sub: assert property (p_doze_sub) else $error("fast alive in sub doze");
    property p_doze_fast;
        power_mode == PWR_DOZE_FAST_ONLY |-> !sub_clk_en && fast_osc_run;
    endproperty
    a_doze_fast: assert property (p_doze_fast) else $error("fast doze gating");
    property p_doze_both;
        power_mode == PWR_DOZE_BOTH_CLOCKS |-> fast_osc_run && slow_osc_run;
    endproperty
    a_doze_both: assert property (p_doze_both) else $error("oscillator off");
    property p_halt;
        halt_req && power_mode == PWR_RUN |=> power_mode != PWR_RUN && !cpu_clk_en;
    endproperty
    a_halt: assert property (p_halt) else $error("halt not taken");
    property p_unstable;
        !fast_osc_stable_flag |-> !fast_clk_en && fast_div_en == 7'h00;
    endproperty
    a_unstable: assert property (p_unstable) else $error("fast tick while unstable");
    property p_taps;
        time_base_clk_en == sub_clk_en && watchdog_clk_en == slow_osc_clk_en;
    endproperty
    a_taps: assert property (p_taps) else $error("timer clock taps");
    property p_switch_bound;
        switch_busy |-> busy_cnt_r < 16'h9c40;
    endproperty
    a_switch_bound: assert property (p_switch_bound) else $error("switch too long");

    c_doze_both: cover property (power_mode == PWR_DOZE_BOTH_CLOCKS);
    c_switch_done: cover property ($fell(switch_busy));
    c_sleep_wdt: cover property (power_mode == PWR_SLEEP && slow_osc_run);
endmodule // clock_mode_sva

bind system_clock_mode_control clock_mode_sva u_sva (
    .ref_clk(ref_clk), .resetn(resetn), .addr(addr), .rd_en(rd_en), .rd_data(rd_data),
    .halt_req(halt_req), .watchdog_en(watchdog_en), .cpu_clk_en(cpu_clk_en),
    .system_clk_en(system_clk_en), .fast_clk_en(fast_clk_en), .fast_div_en(fast_div_en),
    .sub_clk_en(sub_clk_en), .slow_osc_clk_en(slow_osc_clk_en),
    .watchdog_clk_en(watchdog_clk_en), .time_base_clk_en(time_base_clk_en),
    .fast_osc_run(fast_osc_run), .slow_osc_run(slow_osc_run),
    .fast_osc_stable_flag(fast_osc_stable_flag), .switch_busy(switch_busy),
    .power_mode(power_mode)
);

// ### test/test_system_clock_mode_control.sv
`timescale 1ns/1ps
module test_system_clock_mode_control
    import clk_mode_pkg::*;
;
    localparam logic [7:0] ctrl_a = 8'h00;
    localparam logic [7:0] osc_a = 8'h01;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic halt_req = 1'b0;
    logic wake_req = 1'b0;
    logic watchdog_en = 1'b0;
    logic [7:0] rd_data;
    logic cpu_clk_en, system_clk_en, fast_clk_en, sub_clk_en, slow_osc_clk_en;
    logic watchdog_clk_en, time_base_clk_en, fast_osc_run, slow_osc_run;
    logic fast_osc_stable_flag, switch_busy;
    logic [6:0] fast_div_en;
    power_state_t power_mode;
    int err_count = 0;
    int cmp_count = 0;
    int cycles = 0;
    int n_sys, n_fast, n_sub, n_cpu;
    logic [7:0] rv;

    initial
    begin
        forever #2 ref_clk = ~ref_clk;
    end

    system_clock_mode_control DUT (
        .ref_clk(ref_clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rd_data(rd_data), .halt_req(halt_req), .wake_req(wake_req),
        .watchdog_en(watchdog_en), .cpu_clk_en(cpu_clk_en), .system_clk_en(system_clk_en),
        .fast_clk_en(fast_clk_en), .fast_div_en(fast_div_en), .sub_clk_en(sub_clk_en),
        .slow_osc_clk_en(slow_osc_clk_en), .watchdog_clk_en(watchdog_clk_en),
        .time_base_clk_en(time_base_clk_en), .fast_osc_run(fast_osc_run),
        .slow_osc_run(slow_osc_run), .fast_osc_stable_flag(fast_osc_stable_flag),
        .switch_busy(switch_busy), .power_mode(power_mode)
    );

    // ==========================================
    // shared tasks
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        cmp_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic check_rng(input int got, input int lo, input int hi, input string what);
        cmp_count++;
        if (got < lo || got > hi)
        begin
            err_count++;
            $display("wrong value at %0t: %s count %0d", $time, what, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk);
        wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1 d = rd_data;
    endtask

    // pulses are sampled at the falling edge, where the enables have settled
    task automatic count(input int n);
        n_sys = 0;
        n_fast = 0;
        n_sub = 0;
        n_cpu = 0;
        repeat (n)
        begin
            @(negedge ref_clk);
            n_sys += int'(system_clk_en === 1'b1);
            n_fast += int'(fast_clk_en === 1'b1);
            n_sub += int'(sub_clk_en === 1'b1);
            n_cpu += int'(cpu_clk_en === 1'b1);
        end
    endtask

    task automatic wait_idle();
        int i;
        // the switch sees the new select one edge after the write
        repeat (2) @(negedge ref_clk);
        for (i = 0; i < 40000 && switch_busy !== 1'b0; i++)
            @(negedge ref_clk);
        check_rng(i, 0, 39999, "switch time");
    endtask

    // ==========================================
    // scenarios
    task automatic t_regs();
        rd(ctrl_a, rv);
        check(rv, 8'h00, "ctrl reset");
        rd(osc_a, rv);
        check(rv & 8'hfd, 8'h01, "osc reset");
        repeat (300) @(posedge ref_clk);
        rd(osc_a, rv);
        check(rv, 8'h03, "osc stable");
        wr(ctrl_a, 8'h1f);
        rd(ctrl_a, rv);
        check(rv, 8'h03, "ctrl reserved");
        wr(ctrl_a, 8'h00);
        wr(osc_a, 8'hf6);
        rd(osc_a, rv);
        check(rv, 8'h04, "osc restart");
        wr(8'h05, 8'hff);
        rd(8'h05, rv);
        check(rv, 8'h00, "unmapped read");
        rd(ctrl_a, rv);
        check(rv, 8'h00, "unmapped write");
    endtask

    task automatic t_freq();
        int exp_n[4] = '{16, 32, 48, 16};
        for (int f = 0; f < 4; f++)
        begin
            wr(osc_a, {4'h0, 2'(f), 2'b01});
            repeat (300) @(posedge ref_clk);
            count(1000);
            check_rng(n_fast, exp_n[f] - 1, exp_n[f] + 1, "fast rate");
        end
        wr(osc_a, 8'h09);
        repeat (300) @(posedge ref_clk);
    endtask

    task automatic t_divide();
        for (int s = 0; s < 7; s++)
        begin
            wr(ctrl_a, {3'(s), 5'h00});
            wait_idle();
            count(2000);
            check_rng(n_sys, (96 >> s) - 1, (96 >> s) + 2, "divided rate");
            check_rng(n_cpu, n_sys, n_sys, "cpu follows system");
        end
    endtask

    task automatic t_slow();
        wr(ctrl_a, 8'he0);
        wait_idle();
        wr(osc_a, 8'h08);
        count(10000);
        check_rng(n_sys, 1, 2, "sub system rate");
        check_rng(n_sub, 1, 2, "sub rate");
        check({7'h0, fast_osc_run}, 8'h00, "fast osc off");
        wr(osc_a, 8'h09);
        @(negedge ref_clk);
        check({7'h0, fast_osc_run}, 8'h01, "fast osc kept");
    endtask

    task automatic halt_case(input logic [2:0] s, input logic [1:0] k, input power_state_t m,
                             input logic sys_on, input int n);
        wr(ctrl_a, {s, 3'h0, k});
        wait_idle();
        repeat (300) @(posedge ref_clk);
        halt_req <= 1'b1;
        @(posedge ref_clk);
        halt_req <= 1'b0;
        @(negedge ref_clk);
        check({5'h0, power_mode}, {5'h0, m}, "halt mode");
        count(n);
        check_rng(n_cpu, 0, 0, "cpu halted");
        check_rng(n_sys, sys_on ? 1 : 0, sys_on ? n : 0, "halted system");
        check_rng(n_fast, k[1] ? 1 : 0, k[1] ? n : 0, "halted fast");
        check({7'h0, slow_osc_run}, {7'h0, m == PWR_SLEEP ? watchdog_en : 1'b1}, "slow");
        @(posedge ref_clk);
        wake_req <= 1'b1;
        @(posedge ref_clk);
        wake_req <= 1'b0;
        @(negedge ref_clk);
        check({5'h0, power_mode}, {5'h0, PWR_RUN}, "woken");
    endtask

    task automatic t_halt();
        halt_case(3'h0, 2'h0, PWR_SLEEP, 1'b0, 1000);
        @(posedge ref_clk);
        watchdog_en <= 1'b1;
        halt_case(3'h0, 2'h0, PWR_SLEEP, 1'b0, 200);
        halt_case(3'h0, 2'h1, PWR_DOZE_SUB_ONLY, 1'b0, 1000);
        halt_case(3'h0, 2'h3, PWR_DOZE_BOTH_CLOCKS, 1'b1, 1000);
        halt_case(3'h0, 2'h2, PWR_DOZE_FAST_ONLY, 1'b1, 1000);
        halt_case(3'h7, 2'h1, PWR_DOZE_SUB_ONLY, 1'b1, 20000);
        halt_case(3'h7, 2'h2, PWR_DOZE_FAST_ONLY, 1'b0, 1000);
    endtask

    // ==========================================
    // main sequence and hang guard
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 90000)
        begin
            err_count++;
            $display("wrong value at %0t: run timed out", $time);
            end_of_test();
        end
    end

    initial
    begin
        repeat (4) @(posedge ref_clk);
        resetn <= 1'b1;
        t_regs();
        t_freq();
        t_divide();
        // halt cases end on the sub clock: no slow sub-to-fast switch needed
        t_halt();
        t_slow();
        end_of_test();
    end
endmodule // test_system_clock_mode_control
